// File: lwcp_pkg.sv
// Constants shared by the wake and contender pin logic.
// Assumes a 50 MHz system clock and a 32-bit AHB-Lite register port.
package lwcp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS   = 20;
  localparam int LPS_LOW_NS      = 2600;
  // Least time, so round up to whole cycles
  localparam int LPS_LOW_CYC     = (LPS_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_PERIOD_CYC = 8;
  localparam int WAKE_HIGH_CYC   = WAKE_PERIOD_CYC / 2;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses
  localparam int          ADDR_W       = 5;
  localparam logic [4:0]  REG_CTRL     = 5'h00;
  localparam logic [4:0]  REG_STATUS   = 5'h04;
  localparam logic [4:0]  REG_IRQ_STAT = 5'h08;
  localparam logic [4:0]  REG_IRQ_EN   = 5'h0c;
  localparam logic [4:0]  REG_IRQ_CLR  = 5'h10;

  // Control register fields and reset value
  localparam int          CTRL_W           = 2;
  localparam int          CTRL_LINK_ACTIVE = 0;
  localparam int          CTRL_RESUMING_PORT_IRQ_ENABLE        = 1;
  localparam logic [1:0]  CTRL_RESET       = 2'h1;

  // Status register fields
  localparam int          STAT_CONTENDER = 0;
  localparam int          STAT_WAKE      = 1;
  localparam int          STAT_LPS       = 2;
  localparam int          STAT_LLC       = 3;
  localparam int          STAT_STRAP     = 4;

  // Interrupt event bits
  localparam int          IRQ_W       = 3;
  localparam int          IRQ_WAKE_ON = 0;
  localparam int          IRQ_WAKE_OFF = 1;
  localparam int          IRQ_LPS_CHG = 2;
  localparam logic [2:0]  IRQ_RESET   = 3'h0;

  // Bus response
  localparam logic        HRESP_OKAY = 1'b0;

  typedef enum logic {AHB_IDLE, AHB_DATA} lwcp_ahb_e;

endpackage

// File: lwcp_lps_filter.sv
// Link power status filter: judges the link power input inactive
// only after it has stayed low for longer than the qualifying time.
// Assumes the input is synchronous to clk.
`timescale 1ns/1ns
module lwcp_lps_filter
  import lwcp_pkg::*;
#(
  parameter int LOW_CYC = lwcp_pkg::LPS_LOW_CYC
) (
  // Clock, reset, enable
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic ce,
  // Link power status in, filtered level out
  input  wire logic linkPowerStatus,
  output logic      lpsActive
);
  import lwcp_pkg::*;

  localparam int CW = $clog2(LOW_CYC + 1);

  logic [CW-1:0] lowCnt_r;
  logic [CW-1:0] lowCnt_nxt;
  logic          lpsActive_r;
  logic          lpsActive_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // low-time qualify
  // A short low glitch never drops the link; only a long low does
  always_comb begin
    lowCnt_nxt    = lowCnt_r;
    lpsActive_nxt = lpsActive_r;
    if (linkPowerStatus) begin
      lowCnt_nxt    = '0;
      lpsActive_nxt = 1'b1;
    end else if (lowCnt_r < CW'(LOW_CYC)) begin
      lowCnt_nxt = lowCnt_r + CW'(1);
    end else begin
      lpsActive_nxt = 1'b0;
    end
  end

  // Registers, frozen while ce is low
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lowCnt_r    <= '0;
      lpsActive_r <= 1'b0;
    end else if (ce) begin
      lowCnt_r    <= lowCnt_nxt;
      lpsActive_r <= lpsActive_nxt;
    end
  end

  assign lpsActive = lpsActive_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_lps_drop_time: assert property (@(posedge clk) disable iff (!resetn)
    $fell(lpsActive_r) |-> $past(lowCnt_r) == CW'(LOW_CYC) && !$past(linkPowerStatus))
    else $error("link power dropped before the low time elapsed");

  a_lps_recover: assert property (@(posedge clk) disable iff (!resetn)
    ce && linkPowerStatus |=> lpsActive_r)
    else $error("link power high did not read as active");

endmodule

// File: lwcp_wake_pin.sv
// Wake and contender pin logic with its AHB-Lite register slave.
// Assumes a single 50 MHz clock, inputs synchronous to it, and a pad
// outside that resolves the pin from pinOut and pinOe.
//
// Function
// - The pin's strap level is captured as the contender status at the first clock edge after reset is released.
// - After reset the pin is a wake output telling the link controller to power up.
// - An active wake output is a square wave of eight system clock cycles.
// - When wake is not active and reset is over the pin is driven low.
// - During reset the pin is left undriven so that the strap can be read.
// - The link controller counts as inactive when power status is inactive or the control bit is clear.
// - A link-on packet for this node wakes an inactive link controller.
// - The port-event interrupt bit wakes an inactive link controller.
// - Timeout or cable-power interrupt bits wake it when resuming-port enable is set.
// - Once on, wake stays on until the link controller becomes active or a bus reset ends a packet-only wake.
// - A bus reset ends a wake caused only by a link-on packet, not one held by interrupts.
// - Power status reads inactive only after staying low longer than 2.6 us.
// - An interrupt pending while the controller is active wakes it once it goes inactive.
//
// The register offsets and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ns
module lwcp_wake_pin
  import lwcp_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic                  ce,
  // Shared wake and contender pin
  input  wire logic                  pinIn,
  output logic                       pinOut,
  output logic                       pinOe,
  output logic                       contenderStatus,
  // Link controller power status
  input  wire logic                  linkPowerStatus,
  // Wake events from the rest of the device
  input  wire logic                  linkOnPkt,
  input  wire logic                  busReset,
  input  wire logic                  portEventIrq,
  input  wire logic                  configTimeoutIrq,
  input  wire logic                  cablePowerStatusIrq,
  input  wire logic                  stateTimeoutIrq,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  // Interrupt
  output logic                       irq
);
  import lwcp_pkg::*;
  logic              lpsActive;
  logic              llcActive;
  logic              irqCause;
  logic              busWr;
  logic              busRd;
  logic [ADDR_W-1:0] busAddr;
  ////////////////////////////////////////////////////////////////////////////
  // Power status filter
  lwcp_lps_filter #(
    .LOW_CYC (LPS_LOW_CYC)
  ) u_lps (
    .clk             (clk),
    .resetn          (resetn),
    .ce              (ce),
    .linkPowerStatus (linkPowerStatus),
    .lpsActive       (lpsActive)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait state, then the access completes
  lwcp_ahb_e         ahbSt_r;
  lwcp_ahb_e         ahbSt_nxt;
  logic              ahbWrite_r;
  logic              ahbWrite_nxt;
  logic [ADDR_W-1:0] ahbAddr_r;
  logic [ADDR_W-1:0] ahbAddr_nxt;
  logic              hreadyout_r;
  logic              hreadyout_nxt;

  // Accept a transfer only while idle; hsize is ignored, words only
  always_comb begin
    ahbSt_nxt     = ahbSt_r;
    ahbWrite_nxt  = ahbWrite_r;
    ahbAddr_nxt   = ahbAddr_r;
    hreadyout_nxt = hreadyout_r;
    unique case (ahbSt_r)
      AHB_IDLE: begin
        if (hsel && htrans[1] && hready) begin
          ahbSt_nxt     = AHB_DATA;
          ahbWrite_nxt  = hwrite;
          ahbAddr_nxt   = haddr[ADDR_W-1:0];
          hreadyout_nxt = 1'b0;
        end
      end
      AHB_DATA: begin
        ahbSt_nxt     = AHB_IDLE;
        hreadyout_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ahbSt_r     <= AHB_IDLE;
      ahbWrite_r  <= 1'b0;
      ahbAddr_r   <= '0;
      hreadyout_r <= 1'b1;
    end else if (ce) begin
      ahbSt_r     <= ahbSt_nxt;
      ahbWrite_r  <= ahbWrite_nxt;
      ahbAddr_r   <= ahbAddr_nxt;
      hreadyout_r <= hreadyout_nxt;
    end
  end

  assign busWr     = (ahbSt_r == AHB_DATA) && ahbWrite_r;
  assign busRd     = (ahbSt_r == AHB_DATA) && !ahbWrite_r;
  assign busAddr   = ahbAddr_r;
  assign hreadyout = hreadyout_r;
  assign hresp     = HRESP_OKAY; // Never errors; unmapped reads return zero
  ////////////////////////////////////////////////////////////////////////////
  // Strap capture and link activity
  logic              strapDone_r;
  logic              strapDone_nxt;
  logic              contender_r;
  logic              contender_nxt;
  // strap capture
  // Reset cannot load a port value, so the strap is taken at the first edge
  // after release, while the pin is still undriven
  always_comb begin
    strapDone_nxt = 1'b1;
    contender_nxt = strapDone_r ? contender_r : pinIn;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strapDone_r <= 1'b0;
      contender_r <= 1'b0;
    end else if (ce) begin
      strapDone_r <= strapDone_nxt;
      contender_r <= contender_nxt;
    end
  end

  assign contenderStatus = contender_r;
  ////////////////////////////////////////////////////////////////////////////
  // Control register
  logic [CTRL_W-1:0] ctrl_r;
  logic [CTRL_W-1:0] ctrl_nxt;
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (busWr && busAddr == REG_CTRL) begin
      ctrl_nxt = hwdata[CTRL_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= CTRL_RESET;
    end else if (ce) begin
      ctrl_r <= ctrl_nxt;
    end
  end

  assign llcActive = lpsActive && ctrl_r[CTRL_LINK_ACTIVE];
  assign irqCause  = portEventIrq ||
                     (ctrl_r[CTRL_RESUMING_PORT_IRQ_ENABLE] &&
                      (configTimeoutIrq || cablePowerStatusIrq || stateTimeoutIrq));
  ////////////////////////////////////////////////////////////////////////////
  // Wake request and square wave
  logic              pktWake_r;
  logic              pktWake_nxt;
  logic              irqWake_r;
  logic              irqWake_nxt;
  logic              wakeActive_r;
  logic              wakeActive_nxt;
  logic [2:0]        phase_r;
  logic [2:0]        phase_nxt;
  logic              pinOut_r;
  logic              pinOut_nxt;
  logic              pinOe_r;
  logic              pinOe_nxt;
  // wake causes
  // The packet cause and the interrupt cause are kept apart so that a bus
  // reset can drop the first while the second keeps the wave going
  always_comb begin
    pktWake_nxt = 1'b0;
    irqWake_nxt = 1'b0;
    if (strapDone_r && !llcActive) begin
      pktWake_nxt = linkOnPkt || (pktWake_r && !busReset);
      // pending interrupt wakes on going inactive
      irqWake_nxt = irqWake_r || irqCause;
    end
    wakeActive_nxt = pktWake_nxt || irqWake_nxt;
  end

  always_comb begin
    phase_nxt = 3'h0;
    if (wakeActive_nxt && wakeActive_r) begin
      phase_nxt = phase_r + 3'h1; // Wraps every eight cycles
    end
    pinOut_nxt = wakeActive_nxt && (phase_nxt < 3'(WAKE_HIGH_CYC));
    // drive only after the strap is taken
    pinOe_nxt  = strapDone_nxt;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pktWake_r    <= 1'b0;
      irqWake_r    <= 1'b0;
      wakeActive_r <= 1'b0;
      phase_r      <= 3'h0;
      pinOut_r     <= 1'b0;
      pinOe_r      <= 1'b0;
    end else if (ce) begin
      pktWake_r    <= pktWake_nxt;
      irqWake_r    <= irqWake_nxt;
      wakeActive_r <= wakeActive_nxt;
      phase_r      <= phase_nxt;
      pinOut_r     <= pinOut_nxt;
      pinOe_r      <= pinOe_nxt;
    end
  end

  assign pinOut = pinOut_r;
  assign pinOe  = pinOe_r;
  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, enable, clear and read data
  logic [IRQ_W-1:0]  irqStat_r;
  logic [IRQ_W-1:0]  irqStat_nxt;
  logic [IRQ_W-1:0]  irqEn_r;
  logic [IRQ_W-1:0]  irqEn_nxt;
  logic [IRQ_W-1:0]  irqEvt;
  logic [IRQ_W-1:0]  irqClr;
  logic              lpsSeen_r;
  logic              irq_r;
  logic              irq_nxt;
  logic [31:0]       hrdata_r;
  logic [31:0]       hrdata_nxt;
  logic [31:0]       statusWord;
  // Events and clears; a new event beats a clear in the same cycle
  always_comb begin
    irqEvt               = '0;
    irqEvt[IRQ_WAKE_ON]  = wakeActive_nxt && !wakeActive_r;
    irqEvt[IRQ_WAKE_OFF] = !wakeActive_nxt && wakeActive_r;
    irqEvt[IRQ_LPS_CHG]  = lpsActive != lpsSeen_r;
    irqClr               = (busWr && busAddr == REG_IRQ_CLR) ? hwdata[IRQ_W-1:0] : '0;
    irqStat_nxt          = (irqStat_r & ~irqClr) | irqEvt;
    irqEn_nxt            = (busWr && busAddr == REG_IRQ_EN) ? hwdata[IRQ_W-1:0] : irqEn_r;
    irq_nxt              = |(irqStat_nxt & irqEn_nxt);
  end

  // Read mux; reserved and unmapped bits read as zero
  always_comb begin
    statusWord                 = '0;
    statusWord[STAT_CONTENDER] = contender_r;
    statusWord[STAT_WAKE]      = wakeActive_r;
    statusWord[STAT_LPS]       = lpsActive;
    statusWord[STAT_LLC]       = llcActive;
    statusWord[STAT_STRAP]     = strapDone_r;
    hrdata_nxt                 = hrdata_r;
    if (busRd) begin
      unique case (busAddr)
        REG_CTRL:     hrdata_nxt = {{(32-CTRL_W){1'b0}}, ctrl_r};
        REG_STATUS:   hrdata_nxt = statusWord;
        REG_IRQ_STAT: hrdata_nxt = {{(32-IRQ_W){1'b0}}, irqStat_r};
        REG_IRQ_EN:   hrdata_nxt = {{(32-IRQ_W){1'b0}}, irqEn_r};
        default:      hrdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irqStat_r <= IRQ_RESET;
      irqEn_r   <= IRQ_RESET;
      lpsSeen_r <= 1'b0;
      irq_r     <= 1'b0;
      hrdata_r  <= 32'h0000_0000;
    end else if (ce) begin
      irqStat_r <= irqStat_nxt;
      irqEn_r   <= irqEn_nxt;
      lpsSeen_r <= lpsActive;
      irq_r     <= irq_nxt;
      hrdata_r  <= hrdata_nxt;
    end
  end

  assign irq    = irq_r;
  assign hrdata = hrdata_r;
  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Four high cycles from a rising edge of the wave
  sequence sHighRun;
    $rose(pinOut_r) && ce ##1 (ce && wakeActive_r)[*3] ##1 wakeActive_r;
  endsequence
  a_pin_hiz_reset: assert property (!strapDone_r |-> !pinOe_r)
    else $error("pin driven before strap capture");
  a_strap_value: assert property ($rose(strapDone_r) |-> contender_r == $past(pinIn))
    else $error("contender status differs from strap");
  a_pin_drive_on: assert property (strapDone_r |-> pinOe_r)
    else $error("pin not driven after reset");
  a_pin_low_idle: assert property (!wakeActive_r |-> !pinOut_r)
    else $error("pin high while wake inactive");
  a_wave_high_run: assert property (sHighRun |-> !pinOut_r)
    else $error("wave high phase not four cycles");
  a_wave_level: assert property (wakeActive_r |-> pinOut_r == (phase_r < 3'(WAKE_HIGH_CYC)))
    else $error("wave level out of step with phase");
  a_wake_packet: assert property (ce && strapDone_r && !llcActive && linkOnPkt
                                  |=> wakeActive_r)
    else $error("link-on packet did not wake");
  a_wake_port_evt: assert property (ce && strapDone_r && !llcActive && portEventIrq
                                    |=> wakeActive_r)
    else $error("port event did not wake");
  a_wake_resume: assert property (ce && strapDone_r && !llcActive && ctrl_r[CTRL_RESUMING_PORT_IRQ_ENABLE] &&
                                  (configTimeoutIrq || stateTimeoutIrq || cablePowerStatusIrq)
                                  |=> wakeActive_r)
    else $error("enabled timeout interrupt did not wake");
  a_wake_stop: assert property (ce && llcActive |=> !wakeActive_r)
    else $error("wake stayed on with controller active");
  a_wake_hold: assert property (ce && wakeActive_r && !llcActive && !busReset
                                |=> wakeActive_r)
    else $error("wake dropped while controller inactive");
  a_bus_reset_drop: assert property (ce && busReset && !linkOnPkt && !irqWake_r && !irqCause
                                     |=> !wakeActive_r)
    else $error("bus reset left packet-only wake on");
  a_irq_out: assert property (ce |=> irq_r == |(irqStat_r & irqEn_r))
    else $error("interrupt output disagrees with status and enable");
endmodule

// File: lwcp_link_model.sv
// Behavioural model of the link controller that sits on the wake pin.
// Assumes the pin level is already resolved by the bench pad and that
// the bench asks it to power down through sleepReq.
`timescale 1ns/1ns
module lwcp_link_model #(
  parameter int WAKE_DELAY = 8
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Resolved wake pin level and bench request to sleep
  input  wire logic wakeLevel,
  input  wire logic sleepReq,
  // Power status towards the device
  output logic      linkPowerStatus
);
  logic       lps_r, lps_nxt;
  logic       wakePrev_r, wakePrev_nxt;
  logic [7:0] cnt_r, cnt_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Power up only after a rising wake edge, so a stuck-low pin keeps us off
  always_comb begin
    lps_nxt      = lps_r;
    cnt_nxt      = cnt_r;
    wakePrev_nxt = wakeLevel;
    if (sleepReq) begin
      lps_nxt = 1'b0;
      cnt_nxt = 8'h00;
    end else if (!lps_r && cnt_r != 8'h00) begin
      cnt_nxt = cnt_r - 8'h01;
      lps_nxt = (cnt_r == 8'h01);
    end else if (!lps_r && wakeLevel && !wakePrev_r) begin
      cnt_nxt = 8'(WAKE_DELAY);
    end
  end

  // State registers; the controller comes out of reset powered
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lps_r      <= 1'b1;
      cnt_r      <= 8'h00;
      wakePrev_r <= 1'b0;
    end else begin
      lps_r      <= lps_nxt;
      cnt_r      <= cnt_nxt;
      wakePrev_r <= wakePrev_nxt;
    end
  end

  assign linkPowerStatus = lps_r;
endmodule

// File: lwcp_wake_pin_tb_top.sv
// Self-checking bench for the wake and contender pin logic.
// Assumes the pin is pulled to the strap level whenever nobody drives it.
`timescale 1ns/1ns
module lwcp_wake_pin_tb_top;
  import lwcp_pkg::*;

  logic        clk, resetn, strap, sleepReq, ce;
  logic        linkOnPkt, busReset, portEventIrq;
  logic        configTimeoutIrq, cablePowerStatusIrq, stateTimeoutIrq;
  logic        hsel, hwrite;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, rdv;
  wire  [31:0] hrdata;
  wire         pinOut, pinOe, pinWire, contenderStatus, linkPowerStatus;
  wire         hreadyout, hresp, irq;
  int          n_errors, num_checks, k;

  ////////////////////////////////////////////////////////////////////////////
  // Design, link controller model and pad
  lwcp_wake_pin dut_u (.clk(clk), .resetn(resetn), .ce(ce), .pinIn(pinWire),
    .pinOut(pinOut), .pinOe(pinOe), .contenderStatus(contenderStatus),
    .linkPowerStatus(linkPowerStatus), .linkOnPkt(linkOnPkt), .busReset(busReset),
    .portEventIrq(portEventIrq), .configTimeoutIrq(configTimeoutIrq),
    .cablePowerStatusIrq(cablePowerStatusIrq), .stateTimeoutIrq(stateTimeoutIrq),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .irq(irq));
  lwcp_link_model link_u (.clk(clk), .resetn(resetn), .wakeLevel(pinWire),
    .sleepReq(sleepReq), .linkPowerStatus(linkPowerStatus));
  // Strap resistor wins only while the device leaves the pin undriven
  assign pinWire = pinOe ? pinOut : strap;

  // Clock at 50 MHz
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and compare helpers
  task automatic final_report;
    if (n_errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask

  // One AHB single transfer; a slave that never answers is caught by the watchdog
  task automatic ahb(input logic wr, input logic [4:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {27'h0, a};
    hwrite <= wr;
    do @(posedge clk); while (hready_low());
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready_low());
    rdv = hrdata;
  endtask

  function automatic logic hready_low();
    return hreadyout !== 1'b1;
  endfunction

  task automatic rd_chk(input string nm, input logic [4:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(nm, e, rdv & m);
    chk("hresp okay", 32'h0, {31'h0, hresp});
  endtask

  // Wait for a run of equal pin samples; fails if it never comes
  task automatic wait_pin(input string nm, input logic e, input int run, input int maxc);
    int r;
    int i;
    r = 0;
    for (i = 0; i < maxc && r < run; i++) begin
      @(posedge clk);
      #1;
      r = (pinOut === e) ? r + 1 : 0;
    end
    chk(nm, 32'h1, {31'h0, r >= run});
  endtask

  task automatic bus_rst;
    @(posedge clk) busReset <= 1'b1;
    @(posedge clk) busReset <= 1'b0;
  endtask

  // Watchdog at 20000 cycles, well beyond the few hundred cycles the tests need
  initial begin
    #400000;
    n_errors++;
    final_report;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    {resetn, sleepReq, linkOnPkt, busReset, portEventIrq} = 5'h0;
    {configTimeoutIrq, cablePowerStatusIrq, stateTimeoutIrq} = 3'h0;
    {hsel, hwrite, htrans, haddr, hwdata, rdv} = '0;
    strap = 1'b1;
    ce = 1'b1;
    n_errors = 0;
    num_checks = 0;
    repeat (8) @(posedge clk);
    chk("pinOe in reset", 32'h0, {31'h0, pinOe});
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("contender strap", 32'h1, {31'h0, contenderStatus});
    chk("pin idle low", 32'h2, {30'h0, pinOe, pinOut});
    rd_chk("ctrl reset", REG_CTRL, 32'hffffffff, 32'h1);
    rd_chk("irq en reset", REG_IRQ_EN, 32'hffffffff, 32'h0);
    rd_chk("status strap", REG_STATUS, 32'h11, 32'h11);
    rd_chk("unmapped", 5'h14, 32'hffffffff, 32'h0);
    ahb(1'b1, REG_STATUS, 32'h0);
    rd_chk("status read only", REG_STATUS, 32'h1, 32'h1);
    // Packet refused while the controller is active
    @(posedge clk) linkOnPkt <= 1'b1;
    @(posedge clk) linkOnPkt <= 1'b0;
    wait_pin("no wake when active", 1'b0, 12, 12);
    // Packet wake with the control bit clear, then the wave shape
    ahb(1'b1, REG_IRQ_EN, 32'h1);
    ahb(1'b1, REG_CTRL, 32'h0);
    @(posedge clk) linkOnPkt <= 1'b1;
    @(posedge clk) linkOnPkt <= 1'b0;
    for (k = 0; k < 16; k++) begin
      #1 chk("wake wave", {31'h0, (k % 8) < 4}, {31'h0, pinOut});
      @(posedge clk);
    end
    // Clock enable low freezes the wave in its high phase
    @(posedge clk) ce <= 1'b0;
    repeat (5) @(posedge clk);
    #1 chk("ce freeze", 32'h1, {31'h0, pinOut});
    @(posedge clk) ce <= 1'b1;
    chk("irq on wake", 32'h1, {31'h0, irq});
    rd_chk("irq stat on", REG_IRQ_STAT, 32'h1, 32'h1);
    ahb(1'b1, REG_IRQ_CLR, 32'h7);
    rd_chk("irq stat cleared", REG_IRQ_STAT, 32'h1, 32'h0);
    chk("irq cleared", 32'h0, {31'h0, irq});
    ahb(1'b1, REG_IRQ_EN, 32'h0);
    bus_rst;
    wait_pin("packet wake ends", 1'b0, 12, 14);
    rd_chk("irq stat off", REG_IRQ_STAT, 32'h2, 32'h2);
    chk("irq masked", 32'h0, {31'h0, irq});
    // Interrupt pending while active wakes once inactive
    ahb(1'b1, REG_CTRL, 32'h1);
    @(posedge clk) portEventIrq <= 1'b1;
    wait_pin("irq held off", 1'b0, 12, 12);
    ahb(1'b1, REG_CTRL, 32'h0);
    wait_pin("port event wake", 1'b1, 1, 12);
    bus_rst;
    wait_pin("irq wake kept", 1'b1, 1, 10);
    ahb(1'b1, REG_CTRL, 32'h1);
    wait_pin("wake ends active", 1'b0, 12, 20);
    @(posedge clk) portEventIrq <= 1'b0;
    // Each resuming-port cause needs the enable bit
    for (k = 0; k < 3; k++) begin
      ahb(1'b1, REG_CTRL, 32'h0);
      @(posedge clk) begin
        configTimeoutIrq    <= (k == 0);
        cablePowerStatusIrq <= (k == 1);
        stateTimeoutIrq     <= (k == 2);
      end
      wait_pin("no wake unenabled", 1'b0, 12, 12);
      ahb(1'b1, REG_CTRL, 32'h2);
      wait_pin("resume wake", 1'b1, 1, 12);
      @(posedge clk) {configTimeoutIrq, cablePowerStatusIrq, stateTimeoutIrq} <= 3'h0;
      ahb(1'b1, REG_CTRL, 32'h3);
      wait_pin("resume wake ends", 1'b0, 12, 20);
    end
    // Power status must stay low past the qualifying time
    ahb(1'b1, REG_CTRL, 32'h1);
    @(posedge clk) begin
      sleepReq     <= 1'b1;
      portEventIrq <= 1'b1;
    end
    wait_pin("lps not yet low", 1'b0, 120, 120);
    wait_pin("lps low wake", 1'b1, 1, 30);
    @(posedge clk) sleepReq <= 1'b0;
    wait_pin("link powered up", 1'b0, 12, 60);
    @(posedge clk) portEventIrq <= 1'b0;
    // Second reset with the strap low
    @(posedge clk) begin
      strap  <= 1'b0;
      resetn <= 1'b0;
    end
    repeat (3) @(posedge clk);
    #1 chk("pinOe second reset", 32'h0, {31'h0, pinOe});
    @(posedge clk) resetn <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("not contender", 32'h0, {31'h0, contenderStatus});
    final_report;
  end
endmodule
